//--- verilog/dst_pkg.sv
// Purpose: shared constants and carriers of the sample-timing path
// Assumes: mclk is the selected system clock at 100 MHz
// Notes:   frame, bit windows and host latch map live here
package dst_pkg;
	// ----------------------------------------
	// clock and frame timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ          = 100_000_000;
	localparam int unsigned FRAME_HZ        = 256_000;
	localparam int unsigned FRAME_CYC       = CLK_HZ / FRAME_HZ;
	localparam int unsigned INSTR_PER_FRAME = 59;
	localparam int unsigned CLK_PER_INSTR   = 2;
	localparam int unsigned SLOT_CYC        = INSTR_PER_FRAME * CLK_PER_INSTR;
	localparam int unsigned CNT_W           = 9;
	localparam logic [CNT_W-1:0] FRAME_LAST = CNT_W'(FRAME_CYC - 1);
	localparam logic [CNT_W-1:0] SLOT_END   = CNT_W'(SLOT_CYC);

	// ----------------------------------------
	// serial ports: receive bit = 4 clocks, transmit bit = 2 clocks
	// ----------------------------------------
	localparam int unsigned WORD_W          = 16;
	localparam int unsigned RX_BIT_CYC      = 4;
	localparam int unsigned TX_BIT_CYC      = RX_BIT_CYC / 2;
	localparam logic [CNT_W-1:0] RX_START   = 9'h008;
	localparam logic [CNT_W-1:0] RX_END     = CNT_W'(8 + WORD_W * RX_BIT_CYC);
	localparam logic [CNT_W-1:0] TX_START   = 9'h008;
	localparam logic [CNT_W-1:0] TX_END     = CNT_W'(8 + WORD_W * TX_BIT_CYC);
	localparam int unsigned AUX_IN_N        = 4;
	localparam int unsigned SLOW_OUT_N      = 8;

	// ----------------------------------------
	// host latch map (byte index)
	// ----------------------------------------
	localparam int unsigned LATCH_N         = 21;
	localparam logic [4:0] ADR_MODE         = 5'h00;
	localparam logic [4:0] ADR_FREQ0        = 5'h01;
	localparam logic [4:0] ADR_FREQ3        = 5'h04;
	localparam logic [4:0] ADR_SLOW0        = 5'h05;
	localparam int unsigned MODE_EXT_BIT    = 0;
	localparam logic [7:0] LATCH_RST        = 8'h00;
	localparam logic [31:0] FREQ_RST        = 32'h0000_0000;

	typedef struct packed {
		logic       cs_n;
		logic       wr_n;
		logic [4:0] addr;
		logic [7:0] data;
	} dst_host_t;

	typedef struct packed {
		logic [WORD_W-1:0] x;
		logic [WORD_W-1:0] y;
	} dst_xy_t;

	typedef struct packed {
		logic sclk;
		logic ld;
		logic sd_a;
		logic sd_b;
		logic p2s_a;
		logic p2s_b;
	} dst_dac_t;
endpackage

//--- verilog/dst_pair_buf.sv
// Purpose: two-entry buffer for in-phase/quadrature result pairs
// Assumes: one clock, producer and consumer both on mclk
// Notes:   full and empty are exact; ready is combinational
module dst_pair_buf
	import dst_pkg::*;
(
	// clock and reset
	input  wire logic    mclk,
	input  wire logic    arst_n,
	// filling side
	input  wire logic    in_valid,
	output logic         in_ready,
	input  wire dst_xy_t in_data,
	// draining side
	output logic         out_valid,
	input  wire logic    out_ready,
	output dst_xy_t      out_data
);
	typedef struct packed {
		dst_xy_t [1:0] mem;
		logic          wp;
		logic          rp;
		logic [1:0]    cnt;
	} dst_buf_st_t;

	dst_buf_st_t s_q, s_d;
	logic        push, pop;

	assign in_ready  = (s_q.cnt != 2'd2);
	assign out_valid = (s_q.cnt != 2'd0);
	assign out_data  = s_q.mem[s_q.rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb
	begin
		s_d = s_q;
		if (push)
		begin
			s_d.mem[s_q.wp] = in_data;
			s_d.wp          = ~s_q.wp;
		end
		if (pop)
			s_d.rp = ~s_q.rp;
		s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end
endmodule // dst_pair_buf

//--- verilog/dst_sample_timing.sv
// Purpose: frame timing, converter streams, sine synthesis and host latches
// Assumes: mclk is the board clock chosen by clk_sel_ext outside this block
// Notes:   all timing strobes derive from one frame counter; host pins are synced

// Function
// - internal mode: run board from crystal
// - external mode: switch clock to steered oscillator
// - common 256 kHz frame, 59 two-clock instructions
// - squared sine feeds phase comparator
// - host frequency word drives sine synthesis
// - timing derives converter clocks and mux selects
// - main sample enters serial receive port
// - aux stream into serial-to-parallel pair
// - each input channel new sample per frame
// - four converter channels updated every frame
// - transmit port, double rate, one channel each
// - other channels via parallel-to-serial pair
// - sine, in-phase, quadrature get dedicated channels
// - fourth channel multiplexed over eight slow outputs
// - next sine sample each frame by accumulation
// - aux inputs each sampled every four frames
// - bus buffers enabled only during host write
// - latched configuration held until rewritten
// - one decoder makes all strobes
module dst_sample_timing
	import dst_pkg::*;
(
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              arst_n,
	// host bus pins
	input  wire dst_host_t         host_pins,
	output logic                   bus_buf_en_n,
	// clock select and loop
	output logic                   clk_sel_ext,
	output logic                   ref_square,
	output logic                   proc_slot,
	// converter timing and serial inputs
	output logic                   adc_conv,
	output logic                   adc_sclk,
	input  wire logic              adc_main_sd,
	input  wire logic              adc_aux_sd,
	output logic [1:0]             aux_in_sel,
	// received samples
	output logic [WORD_W-1:0]      main_smp,
	output logic                   main_smp_vld,
	output logic [WORD_W-1:0]      aux_smp,
	output logic [1:0]             aux_smp_idx,
	output logic                   aux_smp_vld,
	// result pairs from the processing side
	input  wire logic              xy_valid,
	output logic                   xy_ready,
	input  wire dst_xy_t           xy_data,
	// converter outputs
	output dst_dac_t               dac,
	output logic [2:0]             slow_out_sel
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		dst_host_t                  h_meta;
		dst_host_t                  h_sync;
		logic                       h_wr_prev;
		logic [1:0]                 sd_meta;
		logic [1:0]                 sd_sync;
		logic [LATCH_N-1:0][7:0]    latch;
		logic [31:0]                freq;
		logic [31:0]                phase;
		logic [CNT_W-1:0]           cnt;
		logic [1:0]                 aux_sel;
		logic [2:0]                 slow_sel;
		logic [WORD_W-1:0]          rx_main;
		logic [WORD_W-1:0]          rx_aux;
		logic [WORD_W-1:0]          main_smp;
		logic [WORD_W-1:0]          aux_smp;
		logic [1:0]                 aux_idx;
		logic                       main_vld;
		logic                       aux_vld;
		logic [WORD_W-1:0]          sine;
		dst_xy_t                    xy;
		logic [WORD_W-1:0]          tx_a;
		logic [WORD_W-1:0]          tx_b;
		logic [WORD_W-1:0]          p2s_a;
		logic [WORD_W-1:0]          p2s_b;
		dst_dac_t                   dac;
		logic                       buf_en_n;
		logic                       clk_ext;
		logic                       ref_sq;
		logic                       conv;
		logic                       sclk;
		logic                       slot;
	} dst_st_t;

	dst_st_t s_q, s_d;

	// ----------------------------------------
	// result buffer
	// ----------------------------------------
	logic    pair_vld;
	logic    pair_pop;
	dst_xy_t pair_data;

	dst_pair_buf u_pair_buf
	(
		.mclk      (mclk),
		.arst_n    (arst_n),
		.in_valid  (xy_valid),
		.in_ready  (xy_ready),
		.in_data   (xy_data),
		.out_valid (pair_vld),
		.out_ready (pair_pop),
		.out_data  (pair_data)
	);

	// a pair is taken only at frame start; an empty buffer repeats the last pair
	assign pair_pop = (s_q.cnt == FRAME_LAST);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	logic             frame_end;
	logic             rx_win;
	logic             tx_win;
	logic             host_wr_now;
	logic             wr_stb;
	logic [CNT_W-1:0] rx_off;
	logic [15:0]      ph_mag;
	logic [31:0]      ph_prod;
	logic [WORD_W-1:0] slow_word;
	logic [4:0]       slow_adr;
	logic [WORD_W-1:0] sine_nx;

	assign frame_end   = (s_q.cnt == FRAME_LAST);
	assign rx_win      = (s_q.cnt >= RX_START) && (s_q.cnt < RX_END);
	assign tx_win      = (s_q.cnt >= TX_START) && (s_q.cnt < TX_END);
	assign rx_off      = s_q.cnt - RX_START;
	// the write window is the synced select and write level together
	assign host_wr_now = !s_q.h_sync.cs_n && !s_q.h_sync.wr_n;
	// latch on the trailing edge of the write, when the data has settled
	assign wr_stb      = s_q.h_wr_prev && !host_wr_now;

	// parabola over each half turn: close to a sine, no table needed
	assign ph_mag  = {1'b0, s_q.phase[30:16]};
	assign ph_prod = 32'(ph_mag) * 32'(16'h7FFF - ph_mag);
	assign sine_nx = s_q.phase[31] ? WORD_W'(-$signed({1'b0, ph_prod[29:15]}))
	                               : {1'b0, ph_prod[29:15]};

	assign slow_adr  = 5'(ADR_SLOW0 + {s_q.slow_sel, 1'b0});
	assign slow_word = {s_q.latch[slow_adr + 5'd1], s_q.latch[slow_adr]};

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		s_d = s_q;

		// two flip-flops on every pin before use
		s_d.h_meta  = host_pins;
		s_d.h_sync  = s_q.h_meta;
		s_d.sd_meta = {adc_aux_sd, adc_main_sd};
		s_d.sd_sync = s_q.sd_meta;

		// host side: buffers open only while a write is on the bus
		s_d.h_wr_prev = host_wr_now;
		s_d.buf_en_n  = !host_wr_now;

		// single decode of the address into latch strobes
		if (wr_stb && (s_q.h_sync.addr < 5'(LATCH_N)))
		begin
			s_d.latch[s_q.h_sync.addr] = s_q.h_sync.data;
			// frequency word takes effect whole, on its top byte
			if (s_q.h_sync.addr == ADR_FREQ3)
				s_d.freq = {s_q.h_sync.data, s_q.latch[ADR_FREQ0 + 5'd2],
				            s_q.latch[ADR_FREQ0 + 5'd1], s_q.latch[ADR_FREQ0]};
		end

		// mode latch steers the clock source choice
		s_d.clk_ext = s_q.latch[ADR_MODE][MODE_EXT_BIT];

		// ----------------------------------------
		// frame counter
		// ----------------------------------------
		s_d.cnt  = frame_end ? '0 : s_q.cnt + 9'h001;
		s_d.conv = frame_end;
		// processor instruction slots: two clocks each, fixed budget per frame
		s_d.slot = (s_d.cnt < SLOT_END) && !s_d.cnt[0];

		// receive clock: four clocks per bit in the receive window
		s_d.sclk = rx_win && rx_off[1];
		s_d.main_vld = 1'b0;
		s_d.aux_vld  = 1'b0;
		// sample late in the bit to cover the two-flop pin delay
		if (rx_win && (rx_off[1:0] == 2'b11))
		begin
			s_d.rx_main = {s_q.rx_main[WORD_W-2:0], s_q.sd_sync[0]};
			s_d.rx_aux  = {s_q.rx_aux[WORD_W-2:0], s_q.sd_sync[1]};
		end
		if (s_q.cnt == RX_END)
		begin
			s_d.main_smp = s_q.rx_main;
			s_d.main_vld = 1'b1;
			s_d.aux_smp  = s_q.rx_aux;
			s_d.aux_idx  = s_q.aux_sel;
			s_d.aux_vld  = 1'b1;
		end

		// ----------------------------------------
		// frame start: sine step, selects, load words
		// ----------------------------------------
		s_d.dac.ld = frame_end;
		if (frame_end)
		begin
			s_d.phase    = s_q.phase + s_q.freq;
			s_d.sine     = sine_nx;
			s_d.ref_sq   = !s_q.phase[31];
			s_d.aux_sel  = s_q.aux_sel + 2'd1;
			s_d.slow_sel = s_q.slow_sel + 3'd1;
			if (pair_vld)
				s_d.xy = pair_data;
			// transmit pair: sine and in-phase
			s_d.tx_a  = s_q.sine;
			s_d.tx_b  = s_q.xy.x;
			// parallel-to-serial pair: quadrature and slow channel
			s_d.p2s_a = s_q.xy.y;
			s_d.p2s_b = slow_word;
		end

		// transmit clock at twice the receive bit rate
		s_d.dac.sclk = tx_win && s_q.cnt[0];
		if (tx_win && !s_q.cnt[0])
		begin
			s_d.dac.sd_a  = s_q.tx_a[WORD_W-1];
			s_d.dac.sd_b  = s_q.tx_b[WORD_W-1];
			s_d.dac.p2s_a = s_q.p2s_a[WORD_W-1];
			s_d.dac.p2s_b = s_q.p2s_b[WORD_W-1];
			s_d.tx_a  = {s_q.tx_a[WORD_W-2:0], 1'b0};
			s_d.tx_b  = {s_q.tx_b[WORD_W-2:0], 1'b0};
			s_d.p2s_a = {s_q.p2s_a[WORD_W-2:0], 1'b0};
			s_d.p2s_b = {s_q.p2s_b[WORD_W-2:0], 1'b0};
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_q          <= '0;
			s_q.h_meta   <= '{cs_n: 1'b1, wr_n: 1'b1, addr: 5'h00, data: 8'h00};
			s_q.h_sync   <= '{cs_n: 1'b1, wr_n: 1'b1, addr: 5'h00, data: 8'h00};
			s_q.freq     <= FREQ_RST;
			s_q.buf_en_n <= 1'b1;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign bus_buf_en_n = s_q.buf_en_n;
	assign clk_sel_ext  = s_q.clk_ext;
	assign ref_square   = s_q.ref_sq;
	assign proc_slot    = s_q.slot;
	assign adc_conv     = s_q.conv;
	assign adc_sclk     = s_q.sclk;
	assign aux_in_sel   = s_q.aux_sel;
	assign main_smp     = s_q.main_smp;
	assign main_smp_vld = s_q.main_vld;
	assign aux_smp      = s_q.aux_smp;
	assign aux_smp_idx  = s_q.aux_idx;
	assign aux_smp_vld  = s_q.aux_vld;
	assign dac          = s_q.dac;
	assign slow_out_sel = s_q.slow_sel;
endmodule // dst_sample_timing

//--- tb/dst_sample_timing_asserts.sv
// Purpose: port-level timing checks of the sample-timing block
// Assumes: single mclk domain, arst_n async active low
// Notes:   fcnt_q rebuilds the frame position from adc_conv
module dst_sample_timing_asserts
	import dst_pkg::*;
(
	// clock and reset
	input wire logic       mclk,
	input wire logic       arst_n,
	// watched ports
	input wire dst_host_t  host_pins,
	input wire logic       bus_buf_en_n,
	input wire logic       clk_sel_ext,
	input wire logic       proc_slot,
	input wire logic       adc_conv,
	input wire logic       adc_sclk,
	input wire logic [1:0] aux_in_sel,
	input wire logic       main_smp_vld,
	input wire logic       aux_smp_vld,
	input wire dst_dac_t   dac,
	input wire logic [2:0] slow_out_sel
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] fcnt_q;
	logic       seen_q;
	logic [8:0] pos;
	logic       wr_act;
	// first frame after reset may be short, so wait for one conv
	assign pos    = (fcnt_q == 9'h186) ? 9'h000 : fcnt_q;
	assign wr_act = !host_pins.cs_n && !host_pins.wr_n;
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			fcnt_q <= 9'h000;
			seen_q <= 1'b0;
		end
		else
		begin
			fcnt_q <= adc_conv ? 9'h001 : fcnt_q + 9'h001;
			seen_q <= seen_q | adc_conv;
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	property p_frame; seen_q |-> (adc_conv == (fcnt_q == 9'h186)); endproperty
	property p_conv_ld; adc_conv |-> dac.ld ##1 !dac.ld [*8]; endproperty
	// both serial clocks are registered, so they trail the counter by one cycle
	property p_sclk; seen_q && adc_sclk |-> !(pos[1] ^ pos[0]) && pos >= 9'h00b && pos <= 9'h048; endproperty
	property p_dsclk; seen_q && dac.sclk |-> !pos[0] && pos >= 9'h00a && pos <= 9'h028; endproperty
	property p_vld; seen_q && main_smp_vld |-> pos == 9'h049 && aux_smp_vld; endproperty
	property p_slot; seen_q && proc_slot |-> !pos[0] && pos <= 9'h074; endproperty
	property p_aux_sel; $changed(aux_in_sel) |-> adc_conv && aux_in_sel == $past(aux_in_sel) + 2'h1; endproperty
	property p_slow_sel; $changed(slow_out_sel) |-> adc_conv && slow_out_sel == $past(slow_out_sel) + 3'h1; endproperty
	property p_buf; !bus_buf_en_n |-> $past(wr_act, 3); endproperty
	// mode output follows the latch one edge after the buffers close
	property p_latch; $changed(clk_sel_ext) |-> $past(bus_buf_en_n) && !$past(bus_buf_en_n, 2); endproperty
	a_frame: assert property (p_frame) else $error("frame length wrong");
	a_conv_ld: assert property (p_conv_ld) else $error("load not with conversion");
	a_sclk: assert property (p_sclk) else $error("receive clock out of window");
	a_dsclk: assert property (p_dsclk) else $error("transmit clock out of window");
	a_vld: assert property (p_vld) else $error("sample valid misplaced");
	a_slot: assert property (p_slot) else $error("processor slot misplaced");
	a_aux_sel: assert property (p_aux_sel) else $error("aux select step wrong");
	a_slow_sel: assert property (p_slow_sel) else $error("slow select step wrong");
	a_buf: assert property (p_buf) else $error("buffers enabled outside write");
	a_latch: assert property (p_latch) else $error("mode changed outside write end");
	c_frame: cover property (seen_q && adc_conv);
	c_write: cover property ($fell(bus_buf_en_n));
	c_ext: cover property ($rose(clk_sel_ext));
endmodule // dst_sample_timing_asserts

bind dst_sample_timing dst_sample_timing_asserts i_dst_sample_timing_asserts (
	.mclk(mclk), .arst_n(arst_n), .host_pins(host_pins), .bus_buf_en_n(bus_buf_en_n),
	.clk_sel_ext(clk_sel_ext), .proc_slot(proc_slot), .adc_conv(adc_conv), .adc_sclk(adc_sclk),
	.aux_in_sel(aux_in_sel), .main_smp_vld(main_smp_vld), .aux_smp_vld(aux_smp_vld),
	.dac(dac), .slow_out_sel(slow_out_sel));

//--- tb/dst_adc_model.sv
// Purpose: dual serial converter feeding main and aux streams
// Assumes: bit 15-i held at frame positions 8+4i..11+4i
// Notes:   outside the window lines toggle, never hold the last bit
module dst_adc_model
	import dst_pkg::*;
(
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              arst_n,
	// conversion strobe and words to send
	input  wire logic              adc_conv,
	input  wire logic [WORD_W-1:0] main_word,
	input  wire logic [WORD_W-1:0] aux_word,
	// serial lines
	output logic                   adc_main_sd,
	output logic                   adc_aux_sd
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0]        c_q;
	logic [8:0]        off;
	logic [WORD_W-1:0] m_q;
	logic [WORD_W-1:0] a_q;
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			c_q <= 9'h000;
			m_q <= '0;
			a_q <= '0;
		end
		else if (adc_conv)
		begin
			c_q <= 9'h001;
			m_q <= main_word;
			a_q <= aux_word;
		end
		else
			c_q <= c_q + 9'h001;
	end
	always_comb
	begin
		off         = c_q - 9'h008;
		adc_main_sd = c_q[0];
		adc_aux_sd  = !c_q[0];
		if (c_q >= 9'h008 && c_q <= 9'h047)
		begin
			adc_main_sd = m_q[4'hf - off[5:2]];
			adc_aux_sd  = a_q[4'hf - off[5:2]];
		end
	end
endmodule // dst_adc_model

//--- tb/tb_top.sv
// Purpose: self-checking bench of the sample-timing block
// Assumes: host writes and result pairs driven on rising mclk
// Notes:   dac lanes are deserialised on dac.sclk high cycles
module tb_top;
	import dst_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk, arst_n, bus_buf_en_n, clk_sel_ext, ref_square, proc_slot, adc_conv, adc_sclk;
	logic        adc_main_sd, adc_aux_sd, main_smp_vld, aux_smp_vld, xy_valid, xy_ready;
	logic [1:0]  aux_in_sel, aux_smp_idx;
	logic [2:0]  slow_out_sel;
	logic [15:0] main_smp, aux_smp, main_w, aux_w;
	dst_host_t   host_pins;
	dst_xy_t     xy_data;
	dst_dac_t    dac;
	int          err_total, tests_run;

	dst_sample_timing i_dst_sample_timing (.mclk(mclk), .arst_n(arst_n), .host_pins(host_pins),
		.bus_buf_en_n(bus_buf_en_n), .clk_sel_ext(clk_sel_ext), .ref_square(ref_square),
		.proc_slot(proc_slot), .adc_conv(adc_conv), .adc_sclk(adc_sclk), .adc_main_sd(adc_main_sd),
		.adc_aux_sd(adc_aux_sd), .aux_in_sel(aux_in_sel), .main_smp(main_smp), .main_smp_vld(main_smp_vld),
		.aux_smp(aux_smp), .aux_smp_idx(aux_smp_idx), .aux_smp_vld(aux_smp_vld), .xy_valid(xy_valid),
		.xy_ready(xy_ready), .xy_data(xy_data), .dac(dac), .slow_out_sel(slow_out_sel));
	dst_adc_model i_dst_adc_model (.mclk(mclk), .arst_n(arst_n), .adc_conv(adc_conv), .main_word(main_w),
		.aux_word(aux_w), .adc_main_sd(adc_main_sd), .adc_aux_sd(adc_aux_sd));

	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic complete_run;
		if (err_total == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// which 0: dac.ld, 1: main_smp_vld
	task automatic wait_for(input int which);
		int n;
		logic hit;
		n = 0;
		hit = 1'b0;
		while (hit !== 1'b1 && n < 800)
		begin
			@(posedge mclk);
			hit = which == 0 ? dac.ld : main_smp_vld;
			n++;
		end
		if (hit !== 1'b1)
		begin
			err_total++;
			complete_run();
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge mclk);
		host_pins <= '{cs_n: 1'b0, wr_n: 1'b0, addr: a, data: d};
		repeat (3) @(posedge mclk);
		#1 chk(bus_buf_en_n, 1'b0);
		@(posedge mclk);
		host_pins <= '{cs_n: 1'b1, wr_n: 1'b1, addr: a, data: d};
		repeat (3) @(posedge mclk);
		#1 chk(bus_buf_en_n, 1'b1);
		// latched bytes reach the outputs one edge after the strobe
		@(posedge mclk);
		#1;
	endtask

	task automatic cap(output logic [15:0] da, db, pa, pb, output logic [2:0] sel);
		int n;
		n = 0;
		wait_for(0);
		sel = slow_out_sel;
		for (int i = 0; i < 60 && n < 16; i++)
		begin
			@(posedge mclk);
			if (dac.sclk === 1'b1)
			begin
				da = {da[14:0], dac.sd_a};
				db = {db[14:0], dac.sd_b};
				pa = {pa[14:0], dac.p2s_a};
				pb = {pb[14:0], dac.p2s_b};
				n++;
			end
		end
		chk(n, 16);
	endtask

	task automatic t_mode;
		wr(ADR_MODE, 8'h01);
		chk(clk_sel_ext, 1'b1);
		wr(5'h15, 8'h00);
		chk(clk_sel_ext, 1'b1);
		wr(ADR_MODE, 8'h00);
		chk(clk_sel_ext, 1'b0);
	endtask

	task automatic t_slot;
		int n;
		n = 0;
		wait_for(0);
		repeat (390)
		begin
			@(posedge mclk);
			n += int'(proc_slot);
		end
		chk(n, 59);
	endtask

	task automatic t_adc;
		logic [1:0] prev;
		wait_for(1);
		prev = aux_smp_idx;
		for (int f = 0; f < 4; f++)
		begin
			main_w <= 16'h8421 ^ {4{4'(f)}};
			aux_w <= 16'h7bde ^ {4{4'(f + 1)}};
			wait_for(1);
			chk(main_smp, main_w);
			chk(aux_smp, aux_w);
			chk(aux_smp_idx, aux_in_sel);
			chk(aux_smp_idx, 2'(prev + 2'h1));
			prev = aux_smp_idx;
		end
	endtask

	task automatic t_xy;
		int acc;
		logic [15:0] da, db, pa, pb;
		logic [2:0] sel;
		acc = 0;
		wait_for(0);
		xy_valid <= 1'b1;
		xy_data <= '{x: 16'h1111, y: 16'h2222};
		// third offer must be refused while the frame holds both entries
		for (int i = 0; i < 4; i++)
		begin
			@(posedge mclk);
			if (xy_ready === 1'b1)
			begin
				acc++;
				xy_data <= '{x: 16'h3333, y: 16'h4444};
			end
		end
		xy_valid <= 1'b0;
		chk(acc, 2);
		// a popped pair reaches the converter words one frame after its pop
		cap(da, db, pa, pb, sel);
		chk(db, 16'h0000);
		chk(pa, 16'h0000);
		cap(da, db, pa, pb, sel);
		chk(db, 16'h1111);
		chk(pa, 16'h2222);
		cap(da, db, pa, pb, sel);
		chk(db, 16'h3333);
		chk(pa, 16'h4444);
		cap(da, db, pa, pb, sel);
		chk(db, 16'h3333);
	endtask

	task automatic t_slow;
		logic [15:0] da, db, pa, pb;
		logic [2:0] sel;
		for (int k = 0; k < 8; k++)
		begin
			wr(ADR_SLOW0 + 5'(2 * k), 8'(k));
			wr(ADR_SLOW0 + 5'(2 * k + 1), 8'ha5);
		end
		repeat (8)
		begin
			cap(da, db, pa, pb, sel);
			chk(pb, {8'ha5, 5'h00, 3'(sel - 3'h1)});
		end
	endtask

	task automatic t_sine;
		logic s [8];
		logic [15:0] d [8];
		logic [15:0] db, pa, pb;
		logic [2:0] sel;
		wr(ADR_FREQ0, 8'h00);
		wr(ADR_FREQ0 + 5'h01, 8'h00);
		wr(ADR_FREQ0 + 5'h02, 8'h00);
		wr(ADR_FREQ3, 8'h40);
		// quarter turn per frame: square wave period is four frames
		for (int i = 0; i < 8; i++)
		begin
			cap(d[i], db, pa, pb, sel);
			s[i] = ref_square;
		end
		for (int i = 0; i < 6; i++)
			chk(s[i + 2], !s[i]);
		// sine word trails the square of the same phase by one frame
		for (int i = 0; i < 7; i++)
			chk(s[i] ? d[i + 1][15] : (d[i + 1][15] || d[i + 1] == 16'h0000), !s[i]);
	endtask

	initial
	begin
		arst_n = 1'b0;
		host_pins = '{cs_n: 1'b1, wr_n: 1'b1, addr: 5'h00, data: 8'h00};
		xy_valid = 1'b0;
		xy_data = '0;
		main_w = 16'h0000;
		aux_w = 16'h0000;
		err_total = 0;
		tests_run = 0;
		repeat (20) @(posedge mclk);
		chk(bus_buf_en_n, 1'b1);
		chk(clk_sel_ext, 1'b0);
		arst_n <= 1'b1;
		t_mode();
		t_slot();
		t_adc();
		t_xy();
		t_slow();
		t_sine();
		complete_run();
	end
endmodule // tb_top
